// ---- design/acots_pkg.sv ----
// shared constants, types and the offset arithmetic of the offset and trigger stamping stage
package acots_pkg;

  // ==========================================================================
  // register addresses on the configuration port
  localparam logic [7:0] ADDR_ACCEL_X_OFFSET = 8'h00;
  localparam logic [7:0] ADDR_ACCEL_Y_OFFSET = 8'h01;
  localparam logic [7:0] ADDR_ACCEL_Z_OFFSET = 8'h02;
  localparam logic [7:0] ADDR_CONTROL_NINE   = 8'h03;
  localparam logic [7:0] ADDR_CONTROL_FOUR   = 8'h04;
  localparam logic [7:0] ADDR_TRIGGER_CFG    = 8'h05;
  localparam logic [7:0] ADDR_TRIGGER_STATUS = 8'h06;

  // ==========================================================================
  // field positions
  localparam int BIT_OFFSET_APPLY_ENABLE    = 0;
  localparam int BIT_OFFSET_WEIGHT_SELECT   = 1;
  localparam int BIT_TRIGGER_INPUT_POLARITY = 0;
  localparam int BIT_FIRST_LEVEL_ENABLE     = 0;
  localparam int BIT_SECOND_LEVEL_ENABLE    = 1;
  localparam int BIT_TRIGGER_ACCEL_EXTEND   = 2;
  localparam int BIT_STAMP_SENSOR_SELECT    = 3;
  localparam int BIT_STAMP_AXIS_X           = 4;
  localparam int BIT_STAMP_AXIS_Y           = 5;
  localparam int BIT_STAMP_AXIS_Z           = 6;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_OFFSET      = 8'h00;
  localparam logic [7:0] RST_CONTROL     = 8'h00;
  localparam logic [7:0] RST_TRIGGER_CFG = 8'h70;
  localparam logic [7:0] RST_READ_DATA   = 8'h00;

  // ==========================================================================
  // offset scaling: shift of one offset step in output lsbs at the 4 g range
  localparam logic [2:0] SHIFT_FINE   = 3'h3;
  localparam logic [2:0] SHIFT_COARSE = 3'h7;

  typedef enum logic [1:0] {MODE_OFF, MODE_LEVEL, MODE_LATCH} acots_mode_type;

  typedef struct packed {
    logic signed [15:0] z;
    logic signed [15:0] y;
    logic signed [15:0] x;
  } acots_axes_type;

  // ==========================================================================
  // one axis: raw minus scaled signed offset, saturated to 16 bits
  function automatic logic signed [15:0] corr_axis(input logic signed [15:0] raw,
                                                   input logic [7:0] ofs,
                                                   input logic weight,
                                                   input logic [1:0] fs);
    logic [2:0]         sh;
    logic signed [17:0] ofs_w;
    logic signed [17:0] diff;
    sh    = (weight ? SHIFT_COARSE : SHIFT_FINE) - {1'b0, fs};
    ofs_w = $signed({{10{ofs[7]}}, ofs}) <<< sh;
    diff  = $signed({{2{raw[15]}}, raw}) - ofs_w;
    if (diff > 18'sd32767)
      corr_axis = 16'sh7fff;
    else if (diff < -18'sd32768)
      corr_axis = 16'sh8000;
    else
      corr_axis = diff[15:0];
  endfunction : corr_axis

endpackage : acots_pkg

// ---- design/acots_offset_sub.sv ----
// per-axis offset subtraction of accelerometer samples
`timescale 1ns/1ps
module acots_offset_sub (
  input  acots_pkg::acots_axes_type raw,
  input  wire logic [7:0]           ofs_x,
  input  wire logic [7:0]           ofs_y,
  input  wire logic [7:0]           ofs_z,
  input  wire logic                 enable,
  input  wire logic                 weight,
  input  wire logic [1:0]           fs,
  output acots_pkg::acots_axes_type corrected
);

  // ==========================================================================
  // step weight is fixed in g, so the shift shrinks as the range widens
  always_comb
  begin
    corrected = raw;
    if (enable)
    begin
      corrected.x = acots_pkg::corr_axis(raw.x, ofs_x, weight, fs);
      corrected.y = acots_pkg::corr_axis(raw.y, ofs_y, weight, fs);
      corrected.z = acots_pkg::corr_axis(raw.z, ofs_z, weight, fs);
    end
  end

endmodule : acots_offset_sub

// ---- design/acots_trigger.sv ----
// data-enable trigger input: synchroniser, polarity and latched pulse capture
`timescale 1ns/1ps
module acots_trigger (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin_in,
  input  wire logic polarity,
  input  wire logic latched,
  input  wire logic consume,
  output logic      active,
  output logic      pending,
  output logic      stamp_bit
);

  logic sync1_reg;
  logic sync2_reg;
  logic active_d_reg;
  logic pend_reg;
  logic rise;

  // ==========================================================================
  // synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // idle level of the default active-low trigger, so no false edge follows reset
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign active = (sync2_reg == polarity);
  assign rise   = active & ~active_d_reg;

  // ==========================================================================
  // pulse capture; a pulse seen in the consuming cycle is stamped at once
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      active_d_reg <= 1'b0;
      pend_reg     <= 1'b0;
    end
    else
    begin
      active_d_reg <= active;
      if (consume || !latched)
        pend_reg <= 1'b0;
      else if (rise)
        pend_reg <= 1'b1;
    end
  end

  assign pending   = pend_reg;
  assign stamp_bit = latched ? (pend_reg | rise) : active;

  property p_polarity;
    @(posedge clk) disable iff (rst)
      (!$past(rst) && !$past(rst, 2)) |-> active == ($past(pin_in, 2) == polarity);
  endproperty
  a_polarity: assert property (p_polarity) else $error("trigger polarity wrong");

endmodule : acots_trigger

// ---- design/acots_stage.sv ----
// accelerometer offset correction and data-enable stamping stage, top level
`timescale 1ns/1ps
module acots_stage (
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST,
  input  wire logic                 REG_WR_EN,
  input  wire logic                 REG_RD_EN,
  input  wire logic [7:0]           REG_ADDR,
  input  wire logic [7:0]           REG_WR_DATA,
  output logic [7:0]                REG_RD_DATA,
  input  wire logic [1:0]           ACCEL_FS,
  input  wire logic                 FIFO_ENABLE,
  input  acots_pkg::acots_axes_type ACCEL_IN,
  input  wire logic                 ACCEL_IN_VALID,
  input  acots_pkg::acots_axes_type GYRO_IN,
  input  wire logic                 GYRO_IN_VALID,
  output acots_pkg::acots_axes_type ACCEL_OUT,
  output logic                      ACCEL_NEW,
  output logic                      FIFO_ACCEL_PUSH,
  output acots_pkg::acots_axes_type GYRO_OUT,
  output logic                      GYRO_NEW,
  output logic                      FIFO_GYRO_PUSH,
  input  wire logic                 SECOND_INTERRUPT_PIN_SOURCE,
  input  wire logic                 SECOND_INTERRUPT_PIN_IN,
  output logic                      SECOND_INTERRUPT_PIN_OUT,
  output logic                      SECOND_INTERRUPT_PIN_OE
);

  logic [7:0]                ofs_x_reg;
  logic [7:0]                ofs_y_reg;
  logic [7:0]                ofs_z_reg;
  logic [7:0]                ctrl_nine_reg;
  logic [7:0]                ctrl_four_reg;
  logic [7:0]                trig_cfg_reg;
  logic [7:0]                rd_next;
  acots_pkg::acots_mode_type mode;
  acots_pkg::acots_axes_type accel_corr;
  acots_pkg::acots_axes_type accel_next;
  acots_pkg::acots_axes_type gyro_next;
  logic                      stamp_accel;
  logic                      stamp_gyro;
  logic                      trig_active;
  logic                      trig_pending;
  logic                      stamp_bit;
  logic                      consume;
  logic [2:0]                axis_sel;

  // ==========================================================================
  // register writes
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      ofs_x_reg     <= acots_pkg::RST_OFFSET;
      ofs_y_reg     <= acots_pkg::RST_OFFSET;
      ofs_z_reg     <= acots_pkg::RST_OFFSET;
      ctrl_nine_reg <= acots_pkg::RST_CONTROL;
      ctrl_four_reg <= acots_pkg::RST_CONTROL;
      trig_cfg_reg  <= acots_pkg::RST_TRIGGER_CFG;
    end
    else if (REG_WR_EN)
    begin
      case (REG_ADDR)
        acots_pkg::ADDR_ACCEL_X_OFFSET: ofs_x_reg     <= REG_WR_DATA;
        acots_pkg::ADDR_ACCEL_Y_OFFSET: ofs_y_reg     <= REG_WR_DATA;
        acots_pkg::ADDR_ACCEL_Z_OFFSET: ofs_z_reg     <= REG_WR_DATA;
        acots_pkg::ADDR_CONTROL_NINE:   ctrl_nine_reg <= REG_WR_DATA;
        acots_pkg::ADDR_CONTROL_FOUR:   ctrl_four_reg <= REG_WR_DATA;
        acots_pkg::ADDR_TRIGGER_CFG:    trig_cfg_reg  <= REG_WR_DATA;
        default:                        ;
      endcase
    end
  end

  // ==========================================================================
  // register reads, one cycle after the strobe
  always_comb
  begin
    case (REG_ADDR)
      acots_pkg::ADDR_ACCEL_X_OFFSET: rd_next = ofs_x_reg;
      acots_pkg::ADDR_ACCEL_Y_OFFSET: rd_next = ofs_y_reg;
      acots_pkg::ADDR_ACCEL_Z_OFFSET: rd_next = ofs_z_reg;
      acots_pkg::ADDR_CONTROL_NINE:   rd_next = ctrl_nine_reg;
      acots_pkg::ADDR_CONTROL_FOUR:   rd_next = ctrl_four_reg;
      acots_pkg::ADDR_TRIGGER_CFG:    rd_next = trig_cfg_reg;
      acots_pkg::ADDR_TRIGGER_STATUS: rd_next = {6'h00, trig_pending, trig_active};
      default:                        rd_next = acots_pkg::RST_READ_DATA;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      REG_RD_DATA <= acots_pkg::RST_READ_DATA;
    else if (REG_RD_EN)
      REG_RD_DATA <= rd_next;
  end

  // ==========================================================================
  // mode decode; second enable alone is not a documented mode and stays off
  always_comb
  begin
    case (trig_cfg_reg[acots_pkg::BIT_SECOND_LEVEL_ENABLE:acots_pkg::BIT_FIRST_LEVEL_ENABLE])
      2'h1:    mode = acots_pkg::MODE_LEVEL;
      2'h3:    mode = acots_pkg::MODE_LATCH;
      default: mode = acots_pkg::MODE_OFF;
    endcase
  end

  assign axis_sel    = trig_cfg_reg[acots_pkg::BIT_STAMP_AXIS_Z:acots_pkg::BIT_STAMP_AXIS_X];
  // accel needs both the extension and the sensor select
  assign stamp_accel = (mode != acots_pkg::MODE_OFF)
                       && trig_cfg_reg[acots_pkg::BIT_STAMP_SENSOR_SELECT]
                       && trig_cfg_reg[acots_pkg::BIT_TRIGGER_ACCEL_EXTEND];
  assign stamp_gyro  = (mode != acots_pkg::MODE_OFF)
                       && !trig_cfg_reg[acots_pkg::BIT_STAMP_SENSOR_SELECT];
  // a latched stamp is spent by the sample of the stamped sensor only
  assign consume     = (stamp_accel && ACCEL_IN_VALID) || (stamp_gyro && GYRO_IN_VALID);

  acots_trigger u_trigger (
    .clk       (SYS_CLK),
    .rst       (RST),
    .pin_in    (SECOND_INTERRUPT_PIN_IN),
    .polarity  (ctrl_four_reg[acots_pkg::BIT_TRIGGER_INPUT_POLARITY]),
    .latched   (mode == acots_pkg::MODE_LATCH),
    .consume   (consume),
    .active    (trig_active),
    .pending   (trig_pending),
    .stamp_bit (stamp_bit)
  );

  acots_offset_sub u_offset (
    .raw       (ACCEL_IN),
    .ofs_x     (ofs_x_reg),
    .ofs_y     (ofs_y_reg),
    .ofs_z     (ofs_z_reg),
    .enable    (ctrl_nine_reg[acots_pkg::BIT_OFFSET_APPLY_ENABLE]),
    .weight    (ctrl_nine_reg[acots_pkg::BIT_OFFSET_WEIGHT_SELECT]),
    .fs        (ACCEL_FS),
    .corrected (accel_corr)
  );

  // ==========================================================================
  // lsb stamping on the selected axes
  function automatic acots_pkg::acots_axes_type stamp(input acots_pkg::acots_axes_type v,
                                                      input logic on,
                                                      input logic [2:0] sel,
                                                      input logic b);
    stamp = v;
    if (on && sel[0])
      stamp.x[0] = b;
    if (on && sel[1])
      stamp.y[0] = b;
    if (on && sel[2])
      stamp.z[0] = b;
  endfunction : stamp

  assign accel_next = stamp(accel_corr, stamp_accel, axis_sel, stamp_bit);
  assign gyro_next  = stamp(GYRO_IN, stamp_gyro, axis_sel, stamp_bit);

  // ==========================================================================
  // output data registers and fifo push
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      ACCEL_OUT       <= '0;
      ACCEL_NEW       <= 1'b0;
      FIFO_ACCEL_PUSH <= 1'b0;
    end
    else
    begin
      ACCEL_NEW       <= ACCEL_IN_VALID;
      FIFO_ACCEL_PUSH <= ACCEL_IN_VALID && FIFO_ENABLE;
      if (ACCEL_IN_VALID)
        ACCEL_OUT <= accel_next;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      GYRO_OUT       <= '0;
      GYRO_NEW       <= 1'b0;
      FIFO_GYRO_PUSH <= 1'b0;
    end
    else
    begin
      GYRO_NEW       <= GYRO_IN_VALID;
      FIFO_GYRO_PUSH <= GYRO_IN_VALID && FIFO_ENABLE;
      if (GYRO_IN_VALID)
        GYRO_OUT <= gyro_next;
    end
  end

  // ==========================================================================
  // second interrupt pin: released to the trigger source in either mode
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      SECOND_INTERRUPT_PIN_OUT <= 1'b0;
      SECOND_INTERRUPT_PIN_OE  <= 1'b1;
    end
    else
    begin
      SECOND_INTERRUPT_PIN_OUT <= SECOND_INTERRUPT_PIN_SOURCE;
      SECOND_INTERRUPT_PIN_OE  <= (mode == acots_pkg::MODE_OFF);
    end
  end

  // ==========================================================================
  // checks
  property p_offset_on;
    @(posedge SYS_CLK) disable iff (RST)
      (ACCEL_IN_VALID && ctrl_nine_reg[acots_pkg::BIT_OFFSET_APPLY_ENABLE] && !stamp_accel)
      |=> ACCEL_OUT.x == acots_pkg::corr_axis($past(ACCEL_IN.x), $past(ofs_x_reg),
                                              $past(ctrl_nine_reg[1]), $past(ACCEL_FS));
  endproperty
  a_offset_on: assert property (p_offset_on) else $error("offset not applied");

  property p_offset_signed;
    @(posedge SYS_CLK) disable iff (RST)
      (ACCEL_IN_VALID && ctrl_nine_reg[1:0] == 2'h1 && ofs_y_reg == 8'hff
       && ACCEL_FS == 2'h0 && !stamp_accel && ACCEL_IN.y < 16'sh7f00)
      |=> ACCEL_OUT.y == $past(ACCEL_IN.y) + 16'sh0008;
  endproperty
  a_offset_signed: assert property (p_offset_signed) else $error("offset not signed");

  property p_offset_weight;
    @(posedge SYS_CLK) disable iff (RST)
      (ACCEL_IN_VALID && ctrl_nine_reg[1:0] == 2'h3 && ofs_x_reg == 8'h01
       && ACCEL_FS == 2'h3 && !stamp_accel && ACCEL_IN.x > -16'sh7f00)
      |=> ACCEL_OUT.x == $past(ACCEL_IN.x) - 16'sh0010;
  endproperty
  a_offset_weight: assert property (p_offset_weight) else $error("offset weight wrong");

  property p_pin_input;
    @(posedge SYS_CLK) disable iff (RST)
      trig_cfg_reg[acots_pkg::BIT_FIRST_LEVEL_ENABLE] |=> !SECOND_INTERRUPT_PIN_OE;
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("pin not released");

  property p_accel_no_ext;
    @(posedge SYS_CLK) disable iff (RST)
      (ACCEL_IN_VALID && !trig_cfg_reg[acots_pkg::BIT_TRIGGER_ACCEL_EXTEND]
       && !ctrl_nine_reg[acots_pkg::BIT_OFFSET_APPLY_ENABLE])
      |=> ACCEL_OUT == $past(ACCEL_IN);
  endproperty
  a_accel_no_ext: assert property (p_accel_no_ext) else $error("accel stamped");

  property p_level;
    @(posedge SYS_CLK) disable iff (RST)
      (GYRO_IN_VALID && mode == acots_pkg::MODE_LEVEL && stamp_gyro && axis_sel[0])
      |=> GYRO_OUT.x[0] == $past(trig_active) && GYRO_OUT.x[15:1] == $past(GYRO_IN.x[15:1]);
  endproperty
  a_level: assert property (p_level) else $error("level stamp wrong");

  property p_latch_idle;
    @(posedge SYS_CLK) disable iff (RST)
      (GYRO_IN_VALID && mode == acots_pkg::MODE_LATCH && stamp_gyro && axis_sel[1]
       && !trig_pending && !(trig_active && !$past(trig_active)))
      |=> GYRO_OUT.y[0] == 1'b0;
  endproperty
  a_latch_idle: assert property (p_latch_idle) else $error("latched lsb not 0");

  property p_latch_once;
    @(posedge SYS_CLK) disable iff (RST)
      (GYRO_IN_VALID && mode == acots_pkg::MODE_LATCH && stamp_gyro && trig_pending)
      |=> !trig_pending && GYRO_OUT.z[0] == $past(axis_sel[2] ? 1'b1 : GYRO_IN.z[0]);
  endproperty
  a_latch_once: assert property (p_latch_once) else $error("latched pulse lost");

  property p_unselected;
    @(posedge SYS_CLK) disable iff (RST)
      (GYRO_IN_VALID && !axis_sel[1]) |=> GYRO_OUT.y == $past(GYRO_IN.y);
  endproperty
  a_unselected: assert property (p_unselected) else $error("unselected axis changed");

  property p_reset_sel;
    @(posedge SYS_CLK)
      ($past(RST) && !RST) |-> trig_cfg_reg[6:3] == 4'he && ctrl_four_reg[0] == 1'b0;
  endproperty
  a_reset_sel: assert property (p_reset_sel) else $error("reset selection wrong");

  property p_off_pin;
    @(posedge SYS_CLK) disable iff (RST)
      (mode == acots_pkg::MODE_OFF)
      |=> SECOND_INTERRUPT_PIN_OE
          && SECOND_INTERRUPT_PIN_OUT == $past(SECOND_INTERRUPT_PIN_SOURCE);
  endproperty
  a_off_pin: assert property (p_off_pin) else $error("pin not an output");

endmodule : acots_stage

// ---- tb/acots_trigger_source.sv ----
// trigger source model standing on the second interrupt pin
`timescale 1ns/1ps
module acots_trigger_source (
  input  wire logic clk,
  input  wire logic slow,
  input  wire logic want_level,
  input  wire logic dev_oe,
  input  wire logic dev_out,
  output logic      pin_level
);
  logic drive_reg;

  // a slow source lags the requested level by one clock
  always_ff @(posedge clk)
    drive_reg <= want_level;

  // the source drives only while the device has turned the pin to an input
  assign pin_level = dev_oe ? dev_out : (slow ? drive_reg : want_level);
endmodule : acots_trigger_source

// ---- tb/tb_acots_stage.sv ----
// self-checking bench of the offset and trigger stamping stage
`timescale 1ns/1ps
module tb_acots_stage;
  logic                      sys_clk = 1'b0;
  logic                      rst = 1'b1;
  logic                      wr_en = 1'b0;
  logic                      rd_en = 1'b0;
  logic [7:0]                addr = 8'h00;
  logic [7:0]                wdata = 8'h00;
  logic [7:0]                rdata;
  logic [1:0]                fs = 2'h0;
  logic                      fifo_en = 1'b1;
  acots_pkg::acots_axes_type acc_in = '0;
  acots_pkg::acots_axes_type gyr_in = '0;
  logic                      vld = 1'b0;
  acots_pkg::acots_axes_type acc_out;
  acots_pkg::acots_axes_type gyr_out;
  logic                      acc_new, acc_push, gyr_new, gyr_push;
  logic                      pin_src = 1'b0;
  logic                      pin, pin_drv, pin_en;
  logic                      want = 1'b1;
  logic                      slow = 1'b0;
  int                        fail_count = 0;
  int                        tests_run = 0;
  localparam acots_pkg::acots_axes_type RAW = {16'h0064, 16'h0065, 16'h0064};
  localparam acots_pkg::acots_axes_type G0 = {16'h3333, 16'h2222, 16'h1111};

  always #2.5 sys_clk = ~sys_clk;

  acots_stage acots_stage_i (
    .SYS_CLK(sys_clk), .RST(rst), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
    .REG_ADDR(addr), .REG_WR_DATA(wdata), .REG_RD_DATA(rdata), .ACCEL_FS(fs),
    .FIFO_ENABLE(fifo_en), .ACCEL_IN(acc_in), .ACCEL_IN_VALID(vld), .GYRO_IN(gyr_in),
    .GYRO_IN_VALID(vld), .ACCEL_OUT(acc_out), .ACCEL_NEW(acc_new),
    .FIFO_ACCEL_PUSH(acc_push), .GYRO_OUT(gyr_out), .GYRO_NEW(gyr_new),
    .FIFO_GYRO_PUSH(gyr_push), .SECOND_INTERRUPT_PIN_SOURCE(pin_src),
    .SECOND_INTERRUPT_PIN_IN(pin), .SECOND_INTERRUPT_PIN_OUT(pin_drv),
    .SECOND_INTERRUPT_PIN_OE(pin_en)
  );

  acots_trigger_source acots_trigger_source_i (
    .clk(sys_clk), .slow(slow), .want_level(want), .dev_oe(pin_en),
    .dev_out(pin_drv), .pin_level(pin)
  );

  // ==========================================================================
  // access and checking tasks
  task automatic stop_test();
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge sys_clk);
    wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge sys_clk);
    rd_en = 1'b0;
    @(negedge sys_clk);
    check("read data", {40'h0, rdata}, {40'h0, exp});
  endtask : rd

  // both sensors always update together, as at one shared data rate
  task automatic smp();
    int n;
    @(negedge sys_clk);
    acc_in = RAW;
    gyr_in = G0;
    vld = 1'b1;
    @(negedge sys_clk);
    vld = 1'b0;
    n = 0;
    while (gyr_new !== 1'b1 && n < 4)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 4)
    begin
      fail_count++;
      stop_test();
    end
    check("new and push", {44'h0, acc_new, gyr_new, acc_push, gyr_push},
          {44'h0, 2'b11, fifo_en, fifo_en});
  endtask : smp

  function automatic acots_pkg::acots_axes_type stamp(input acots_pkg::acots_axes_type v,
                                                      input logic [2:0] sel,
                                                      input logic b);
    stamp = v;
    if (sel[0])
      stamp.x[0] = b;
    if (sel[1])
      stamp.y[0] = b;
    if (sel[2])
      stamp.z[0] = b;
  endfunction : stamp

  task automatic pin_oe(input logic exp);
    repeat (2) @(negedge sys_clk);
    check("pin enable", {47'h0, pin_en}, {47'h0, exp});
  endtask : pin_oe

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    rd(acots_pkg::ADDR_TRIGGER_CFG, 8'h70);
    rd(acots_pkg::ADDR_CONTROL_NINE, 8'h00);
    rd(8'h3c, 8'h00);
    pin_oe(1'b1);
    // offsets kept within -127..127 by the host
    wr(acots_pkg::ADDR_ACCEL_X_OFFSET, 8'h01);
    wr(acots_pkg::ADDR_ACCEL_Y_OFFSET, 8'hff);
    wr(acots_pkg::ADDR_ACCEL_Z_OFFSET, 8'h7f);
    rd(acots_pkg::ADDR_ACCEL_Y_OFFSET, 8'hff);
    smp();
    check("accel bypass", acc_out, RAW);
    check("gyro untouched", gyr_out, G0);
    wr(acots_pkg::ADDR_CONTROL_NINE, 8'h01);
    smp();
    check("accel fine", acc_out, {16'hfc6c, 16'h006d, 16'h005c});
    wr(acots_pkg::ADDR_CONTROL_NINE, 8'h03);
    smp();
    check("accel coarse", acc_out, {16'hc0e4, 16'h00e5, 16'hffe4});
    fs = 2'h3;
    smp();
    check("accel coarse 32g", acc_out, {16'hf874, 16'h0075, 16'h0054});
    wr(acots_pkg::ADDR_CONTROL_NINE, 8'h01);
    smp();
    check("accel fine 32g", acc_out, {16'hffe5, 16'h0066, 16'h0063});
    fs = 2'h0;
    wr(acots_pkg::ADDR_CONTROL_NINE, 8'h00);
    // level mode, trigger active low, pin idle high
    wr(acots_pkg::ADDR_TRIGGER_CFG, 8'h71);
    pin_oe(1'b0);
    smp();
    check("gyro level idle", gyr_out, stamp(G0, 3'h7, 1'b0));
    want = 1'b0;
    repeat (4) @(negedge sys_clk);
    smp();
    check("gyro level low", gyr_out, stamp(G0, 3'h7, 1'b1));
    check("accel not stamped", acc_out, RAW);
    want = 1'b1;
    smp();
    check("late change", gyr_out, stamp(G0, 3'h7, 1'b1));
    smp();
    check("change seen", gyr_out, stamp(G0, 3'h7, 1'b0));
    wr(acots_pkg::ADDR_CONTROL_FOUR, 8'h01);
    repeat (4) @(negedge sys_clk);
    smp();
    check("gyro level high", gyr_out, stamp(G0, 3'h7, 1'b1));
    rd(acots_pkg::ADDR_TRIGGER_STATUS, 8'h01);
    wr(acots_pkg::ADDR_TRIGGER_CFG, 8'h11);
    smp();
    check("x only", gyr_out, stamp(G0, 3'h1, 1'b1));
    wr(acots_pkg::ADDR_TRIGGER_CFG, 8'h79);
    smp();
    check("no extend accel", acc_out, RAW);
    check("no extend gyro", gyr_out, G0);
    wr(acots_pkg::ADDR_TRIGGER_CFG, 8'h7d);
    smp();
    check("extend accel", acc_out, stamp(RAW, 3'h7, 1'b1));
    check("extend gyro", gyr_out, G0);
    // latched mode with a slow source
    slow = 1'b1;
    want = 1'b0;
    wr(acots_pkg::ADDR_TRIGGER_CFG, 8'h73);
    repeat (4) @(negedge sys_clk);
    smp();
    check("latch idle", gyr_out, stamp(G0, 3'h7, 1'b0));
    want = 1'b1;
    repeat (3) @(negedge sys_clk);
    want = 1'b0;
    repeat (4) @(negedge sys_clk);
    rd(acots_pkg::ADDR_TRIGGER_STATUS, 8'h02);
    smp();
    check("latch first", gyr_out, stamp(G0, 3'h7, 1'b1));
    smp();
    check("latch after", gyr_out, stamp(G0, 3'h7, 1'b0));
    // second enable alone leaves the modes off
    wr(acots_pkg::ADDR_TRIGGER_CFG, 8'h72);
    pin_oe(1'b1);
    pin_src = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("pin output", {47'h0, pin_drv}, {47'h0, 1'b1});
    smp();
    check("modes off", gyr_out, G0);
    stop_test();
  end
endmodule : tb_acots_stage
